// ===== inc/pbg_pkg.sv
// package: constants and types for the pad behaviour and gpio block
package pbg_pkg;
    // clock is 10 MHz here; fixed clock output uses the divider below
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned FIXCLK_HZ     = 4_608_000;
    // a 50% square wave needs a whole half-period count of at least one cycle
    localparam int unsigned FIXCLK_HALF   = (CLK_HZ / (2 * FIXCLK_HZ)) < 1 ? 1 :
                                            (CLK_HZ / (2 * FIXCLK_HZ));
    localparam int unsigned P1_STRONG_CYC = 2;
    localparam logic [8:0]  GPO_RESET     = 9'h1ff;
    localparam logic [7:0]  PORT_ONES     = 8'hff;
    localparam logic [7:0]  PORT_ZERO     = 8'h00;

    typedef enum logic [1:0] {
        PBG_MODE_NORMAL = 2'b00,
        PBG_MODE_TEST   = 2'b01,
        PBG_MODE_EMUL   = 2'b11
    } pbg_mode_t;

    typedef enum logic [1:0] {
        PBG_TRI_LOW  = 2'b00,
        PBG_TRI_OPEN = 2'b01,
        PBG_TRI_HIGH = 2'b11
    } pbg_tri_t;

    typedef enum logic [1:0] {
        PBG_ST_RESET = 2'b00,
        PBG_ST_RUN   = 2'b01,
        PBG_ST_SHUT  = 2'b11
    } pbg_state_t;
endpackage

// ===== inc/pbg_edge_if.sv
// interface: synchronised pin levels and their change pulses
`timescale 1ns/1ps
`default_nettype none
interface pbg_edge_if #(parameter int W = 4);
    logic [W-1:0] level;
    logic [W-1:0] change;
    modport src (output level, output change);
    modport dst (input level, input change);
endinterface
`default_nettype wire

// ===== logic/pbg_sync_edge.sv
// module: two-flop synchroniser with change detection per bit
`timescale 1ns/1ps
`default_nettype none
module pbg_sync_edge #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // raw pins
    input  wire logic [W-1:0] pinIn,
    // synchronised result
    pbg_edge_if.src           edges
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;

    // no reset: the chain settles on the pin level while reset is held,
    // so a pin idling high gives no false change pulse after release
    always_ff @(posedge clk)
    begin
        meta   <= pinIn;
        stable <= meta;
        prev   <= stable;
    end

    assign edges.level  = stable;
    assign edges.change = stable ^ prev;

    anyEdge_a: assert property (@(posedge clk) disable iff (!resetn)
        ($rose(stable[0]) || $fell(stable[0])) |-> edges.change[0])
        else $error("pin change not flagged");
endmodule
`default_nettype wire

// ===== logic/pbg_fixclk_div.sv
// module: enable-driven divider for the fixed clock output
`timescale 1ns/1ps
`default_nettype none
module pbg_fixclk_div #(
    parameter int unsigned HALF = pbg_pkg::FIXCLK_HALF
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // run control
    input  wire logic run,
    // divided square wave
    output var  logic clkOut
);
    logic [7:0] cnt;

    always_ff @(posedge clk)
    begin
        if (!resetn || !run)
        begin
            cnt    <= 8'h00;
            clkOut <= 1'b0;
        end
        else if (cnt == 8'(HALF - 1))
        begin
            cnt    <= 8'h00;
            clkOut <= ~clkOut;
        end
        else
        begin
            cnt <= cnt + 8'h01;
        end
    end

    halfPeriod_a: assert property (@(posedge clk) disable iff (!resetn || !run)
        (cnt == 8'(HALF - 1)) |=> (clkOut != $past(clkOut)))
        else $error("fixed clock did not toggle");
endmodule
`default_nettype wire

// ===== logic/pbg_pads.sv
// module: pad behaviour across normal, reset, shutdown and emulation
//
// Contract
// - fixed clock output, 50% duty, divided
// - shutdown freezes voice/cipher output pin levels
// - separate active-high rx and tx window strobes
// - sync pin accepts external 500 Hz frame input
// - voice stream with bit and frame clocks
// - host clocks pcm; device passes samples
// - latch strobe driven normally, input in emulation
// - select pins decode normally, irq in emulation
// - third select: decode or core clock
// - port 0 pull/hold/float per mode
// - port 1 one driven strongly two cycles
// - port 1 change irq, hold, float, pullups
// - port 2 upper address or latch byte
// - write/read strobes: output normal, input emulation
// - fetch strobe weak high shutdown, float emulation
// - general outputs hold level, reset to one
// - three-level input readable, or general output
// - mode strap sampled during reset sets emulation
// - external irq on every change
// - serial clock and data low when idle
// - reset line open drain, watchdog pulls low
// - strap high normal, open test, low emulation
`timescale 1ns/1ps
`default_nettype none
module pbg_pads (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // chip state controls
    input  wire logic               shutdownReq,
    input  wire logic               watchdogExpire,
    input  wire logic               serialEnable,
    // internal functional sources
    input  wire logic               rxWindow,
    input  wire logic               txWindow,
    input  wire logic [3:0]         voiceOut,
    input  wire logic [1:0]         cipherOut,
    input  wire logic [8:0]         gpoLevel,
    input  wire logic [8:0]         gpoSelect,
    input  wire logic               selCoreClock,
    input  wire logic [2:0]         addrDecodeN,
    input  wire logic [1:0]         coreIrq,
    input  wire logic               coreClock,
    input  wire logic               latchStrobe,
    input  wire logic               writeStrobeN,
    input  wire logic               readStrobeN,
    input  wire logic               fetchStrobeN,
    input  wire logic               fetchOrWide,
    input  wire logic [15:8]        addrHigh,
    input  wire logic [7:0]         port2Latch,
    input  wire logic [7:0]         port0Out,
    input  wire logic               port0Drive,
    input  wire logic [7:0]         port1Latch,
    input  wire logic [7:0]         port1IrqEnable,
    input  wire logic [7:0]         port1PullupOff,
    input  wire logic               syncInSelect,
    input  wire logic               serialClk,
    input  wire logic               serialData,
    input  wire logic               pcmDataOut,
    // pins in
    input  wire logic               radio_rx_data,
    input  wire logic               frame_sync_io,
    input  wire logic               pcm_bit_clock,
    input  wire logic               pcm_tx_strobe,
    input  wire logic               pcm_rx_strobe,
    input  wire logic               pcm_tx_data_in,
    input  wire logic               ext_irq_a,
    input  wire logic               ext_irq_b,
    input  wire logic               ext_irq_c_or_antenna_switch,
    input  wire logic               resetPinIn,
    input  wire logic               strapLow,
    input  wire logic               strapHigh,
    input  wire logic               triLowIn,
    input  wire logic               triHighIn,
    input  wire logic               latchPinIn,
    input  wire logic               writePinInN,
    input  wire logic               readPinInN,
    input  wire logic [7:0]         port1PinIn,
    // pins out
    output var  logic               fixed_clock_out,
    output var  logic               rx_window_strobe,
    output var  logic               tx_window_strobe,
    output var  logic [5:0]         voicePinOut,
    output var  logic [5:0]         voicePinOe_n,
    output var  logic               three_level_in_or_gpo_g,
    output var  logic               triPinOe_n,
    output var  logic               decode_sel_a_or_irq_a,
    output var  logic               decode_sel_b_or_irq_b,
    output var  logic               decode_sel_c_or_core_clock,
    output var  logic               latchPinOut,
    output var  logic               latchPinOe_n,
    output var  logic               writePinOutN,
    output var  logic               readPinOutN,
    output var  logic               strobePinOe_n,
    output var  logic               prog_fetch_strobe,
    output var  logic               fetchPinOe_n,
    output var  logic               fetchWeakHigh,
    output var  logic [7:0]         port0PinOut,
    output var  logic [7:0]         port0PinOe_n,
    output var  logic [7:0]         port0WeakHigh,
    output var  logic [7:0]         port1PinOut,
    output var  logic [7:0]         port1PinOe_n,
    output var  logic [7:0]         port1WeakHigh,
    output var  logic [7:0]         port2PinOut,
    output var  logic [7:0]         port2PinOe_n,
    output var  logic               sync_serial_dout,
    output var  logic               serialClkPin,
    output var  logic               pcm_rx_data_out,
    output var  logic               resetPinOut,
    output var  logic               resetPinOe_n,
    // status to software
    output var  logic               emulationMode,
    output var  logic               testMode,
    output var  logic [1:0]         triLevel,
    output var  logic [7:0]         port1IrqFlag,
    output var  logic [2:0]         extIrqFlag,
    output var  logic               frameSyncPulse,
    output var  logic               radioRxBit,
    output var  logic [2:0]         pcmSyncLevel,
    output var  logic               pcmTxSample
);
    // ==========================================================
    // synchronisers
    // ==========================================================
    pbg_edge_if #(.W(3)) extE ();
    pbg_edge_if #(.W(6)) auxE ();
    pbg_edge_if #(.W(8)) p1E ();

    pbg_sync_edge #(.W(3)) uExt (
        .clk    (clk),
        .resetn (resetn),
        .pinIn  ({ext_irq_c_or_antenna_switch, ext_irq_b, ext_irq_a}),
        .edges  (extE)
    );
    pbg_sync_edge #(.W(6)) uAux (
        .clk    (clk),
        .resetn (resetn),
        .pinIn  ({pcm_tx_data_in, pcm_rx_strobe, pcm_tx_strobe,
                  pcm_bit_clock, frame_sync_io, radio_rx_data}),
        .edges  (auxE)
    );
    pbg_sync_edge #(.W(8)) uP1 (
        .clk    (clk),
        .resetn (resetn),
        .pinIn  (port1PinIn),
        .edges  (p1E)
    );

    // ==========================================================
    // mode strap and chip state
    // ==========================================================
    pbg_pkg::pbg_state_t state;
    pbg_pkg::pbg_mode_t  mode;
    logic [1:0]          strapMeta;
    logic [1:0]          strapSync;
    logic                shut;

    // strap synchronised, then caught while reset is held
    always_ff @(posedge clk)
    begin
        strapMeta <= {strapHigh, strapLow};
        strapSync <= strapMeta;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            case (strapSync)
                2'b01:   mode <= pbg_pkg::PBG_MODE_EMUL;
                2'b10:   mode <= pbg_pkg::PBG_MODE_NORMAL;
                default: mode <= pbg_pkg::PBG_MODE_TEST;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            state <= pbg_pkg::PBG_ST_RESET;
        else
        begin
            case (state)
                pbg_pkg::PBG_ST_RESET: state <= pbg_pkg::PBG_ST_RUN;
                pbg_pkg::PBG_ST_RUN:
                    if (shutdownReq)
                        state <= pbg_pkg::PBG_ST_SHUT;
                pbg_pkg::PBG_ST_SHUT:
                    if (!shutdownReq)
                        state <= pbg_pkg::PBG_ST_RUN;
                default: state <= pbg_pkg::PBG_ST_RESET;
            endcase
        end
    end

    assign shut          = (state == pbg_pkg::PBG_ST_SHUT);
    assign emulationMode = (mode == pbg_pkg::PBG_MODE_EMUL);
    assign testMode      = (mode == pbg_pkg::PBG_MODE_TEST);

    // ==========================================================
    // fixed clock and radio strobes
    // ==========================================================
    pbg_fixclk_div uDiv (
        .clk    (clk),
        .resetn (resetn),
        .run    (!shut),
        .clkOut (fixed_clock_out)
    );

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rx_window_strobe <= 1'b0;
            tx_window_strobe <= 1'b0;
        end
        else
        begin
            rx_window_strobe <= rxWindow;
            tx_window_strobe <= txWindow;
        end
    end

    // radio and pcm inputs only ever read after two flops
    assign radioRxBit     = auxE.level[0];
    assign frameSyncPulse = syncInSelect & auxE.change[1] & auxE.level[1];
    assign pcmSyncLevel   = auxE.level[4:2];
    assign pcmTxSample    = auxE.level[5];

    always_ff @(posedge clk)
    begin
        if (!resetn)
            pcm_rx_data_out <= 1'b0;
        else if (auxE.change[2] && auxE.level[2])
            pcm_rx_data_out <= pcmDataOut;
    end

    // ==========================================================
    // multifunction voice, cipher and general outputs
    // ==========================================================
    logic [5:0] funcSrc;
    logic [8:0] gpoReg;
    assign funcSrc = {cipherOut, voiceOut};

    always_ff @(posedge clk)
    begin
        if (!resetn)
            gpoReg <= pbg_pkg::GPO_RESET;
        else if (!shut)
            gpoReg <= gpoLevel;
    end

    // frozen in shutdown: a voice clock must not glitch the codec mid-sleep
    always_ff @(posedge clk)
    begin
        if (!resetn)
            voicePinOut <= pbg_pkg::GPO_RESET[5:0];
        else if (!shut)
        begin
            for (int i = 0; i < 6; i++)
                voicePinOut[i] <= gpoSelect[i] ? gpoLevel[i] : funcSrc[i];
        end
    end
    // cipher input pin (bit 5) is an input unless used as output
    assign voicePinOe_n = {~gpoSelect[5], 5'b0_0000};

    // ==========================================================
    // three-level input
    // ==========================================================
    logic [1:0] triMeta;
    logic [1:0] triSync;
    always_ff @(posedge clk)
    begin
        triMeta <= {triHighIn, triLowIn};
        triSync <= triMeta;
    end
    always_ff @(posedge clk)
    begin
        if (!resetn)
            triLevel <= pbg_pkg::PBG_TRI_OPEN;
        else
        begin
            case (triSync)
                2'b01:   triLevel <= pbg_pkg::PBG_TRI_LOW;
                2'b10:   triLevel <= pbg_pkg::PBG_TRI_HIGH;
                default: triLevel <= pbg_pkg::PBG_TRI_OPEN;
            endcase
        end
    end
    assign three_level_in_or_gpo_g = gpoReg[8];
    assign triPinOe_n              = ~gpoSelect[8];

    // ==========================================================
    // microcontroller bus pins
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            decode_sel_a_or_irq_a      <= 1'b1;
            decode_sel_b_or_irq_b      <= 1'b1;
            decode_sel_c_or_core_clock <= 1'b1;
            port2PinOut                <= pbg_pkg::PORT_ONES;
        end
        else
        begin
            decode_sel_a_or_irq_a <= emulationMode ? coreIrq[0] : addrDecodeN[0];
            decode_sel_b_or_irq_b <= emulationMode ? coreIrq[1] : addrDecodeN[1];
            decode_sel_c_or_core_clock <= (selCoreClock || emulationMode) ?
                                          coreClock : addrDecodeN[2];
            port2PinOut <= fetchOrWide ? addrHigh : port2Latch;
        end
    end

    assign latchPinOut   = latchStrobe;
    assign latchPinOe_n  = emulationMode;
    assign writePinOutN  = writeStrobeN;
    assign readPinOutN   = readStrobeN;
    assign strobePinOe_n = emulationMode;
    assign port2PinOe_n  = {8{emulationMode | shut | (state == pbg_pkg::PBG_ST_RESET)}};

    // fetch strobe: weak high in shutdown, floating in emulation
    assign prog_fetch_strobe = fetchStrobeN;
    assign fetchPinOe_n      = emulationMode | shut;
    assign fetchWeakHigh     = shut & ~emulationMode;

    // ==========================================================
    // port 0 and port 1
    // ==========================================================
    logic [7:0] p0Last;
    logic [7:0] p1Prev;
    logic [1:0] p1Strong [8];

    always_ff @(posedge clk)
    begin
        if (!resetn)
            p0Last <= pbg_pkg::PORT_ONES;
        else if (!shut && port0Drive)
            p0Last <= port0Out;
    end

    always_comb
    begin
        port0PinOut   = shut ? pbg_pkg::PORT_ZERO : port0Out;
        port0PinOe_n  = pbg_pkg::PORT_ONES;
        port0WeakHigh = pbg_pkg::PORT_ZERO;
        if (emulationMode)
            port0PinOe_n = pbg_pkg::PORT_ONES;
        else if (state == pbg_pkg::PBG_ST_RESET)
            port0WeakHigh = pbg_pkg::PORT_ONES;
        else if (shut)
        begin
            port0PinOe_n  = p0Last;
            port0WeakHigh = p0Last;
        end
        else if (port0Drive)
            port0PinOe_n = pbg_pkg::PORT_ZERO;
    end

    // strong drive for two cycles after a pin turns to one, then pull-up only
    always_ff @(posedge clk)
    begin
        if (!resetn)
            p1Prev <= pbg_pkg::PORT_ONES;
        else if (!shut)
            p1Prev <= port1Latch;
    end

    for (genvar g = 0; g < 8; g++)
    begin : gP1
        always_ff @(posedge clk)
        begin
            if (!resetn)
                p1Strong[g] <= 2'b00;
            else if (port1Latch[g] && !p1Prev[g] && !shut)
                p1Strong[g] <= 2'(pbg_pkg::P1_STRONG_CYC);
            else if (p1Strong[g] != 2'b00)
                p1Strong[g] <= p1Strong[g] - 2'b01;
        end
        assign port1PinOut[g]   = p1Prev[g];
        assign port1PinOe_n[g]  = emulationMode | (p1Prev[g] & (p1Strong[g] == 2'b00));
        assign port1WeakHigh[g] = ~emulationMode & ~port1PullupOff[g];
    end

    // ==========================================================
    // interrupt flags: a one-cycle pulse per change, with no latched set or clear
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            port1IrqFlag <= pbg_pkg::PORT_ZERO;
            extIrqFlag   <= 3'b000;
        end
        else
        begin
            port1IrqFlag <= p1E.change & port1IrqEnable;
            extIrqFlag   <= extE.change;
        end
    end

    // ==========================================================
    // serial port and reset pin
    // ==========================================================
    always_comb
    begin
        serialClkPin     = 1'b0;
        sync_serial_dout = 1'b0;
        if (serialEnable && !shut)
        begin
            serialClkPin     = serialClk;
            sync_serial_dout = serialData;
        end
    end

    // open drain: pulls low only, never in emulation where it is input only
    assign resetPinOut  = 1'b0;
    assign resetPinOe_n = emulationMode | ~watchdogExpire;

    // ==========================================================
    // checks
    // ==========================================================
    sequence shutEntry_s;
        !shut ##1 shut;
    endsequence

    holdShut_a: assert property (@(posedge clk) disable iff (!resetn)
        shutEntry_s |=> $stable(voicePinOut))
        else $error("voice pins changed in shutdown");
    gpoReset_a: assert property (@(posedge clk) disable iff (!resetn)
        $past(!resetn) |-> gpoReg == pbg_pkg::GPO_RESET)
        else $error("general outputs not one after reset");
    serialLow_a: assert property (@(posedge clk) disable iff (!resetn)
        (shut || !serialEnable) |-> !serialClkPin && !sync_serial_dout)
        else $error("serial pins not low");
    resetOd_a: assert property (@(posedge clk) disable iff (!resetn)
        emulationMode |-> resetPinOe_n)
        else $error("reset pin driven in emulation");
    selIrq_a: assert property (@(posedge clk) disable iff (!resetn)
        emulationMode ##1 emulationMode |-> decode_sel_a_or_irq_a == $past(coreIrq[0]))
        else $error("select pin not carrying irq");
    strongTwo_a: assert property (@(posedge clk) disable iff (!resetn)
        (p1Strong[0] == 2'b01) |=> (p1Strong[0] == 2'b00))
        else $error("port 1 strong drive too long");
    busFloat_a: assert property (@(posedge clk) disable iff (!resetn)
        emulationMode |-> strobePinOe_n && latchPinOe_n && fetchPinOe_n)
        else $error("bus strobes driven in emulation");
    strobeWin_a: assert property (@(posedge clk) disable iff (!resetn)
        txWindow |=> tx_window_strobe)
        else $error("tx strobe missing");
endmodule
`default_nettype wire

// ===== testbench/pbg_far_side.sv
// far-side pin model: pulled-up reset line and interrupt sources
`timescale 1ns/1ps
`default_nettype none
module pbg_far_side (
    // bench commands and device reset driver
    input  wire logic [2:0] irqCmd,
    input  wire logic       rstOut,
    input  wire logic       rstOe_n,
    // pin levels
    output var  logic [2:0] irqPin,
    output var  logic       rstLine
);
    // the external pull-up wins whenever the device lets go
    assign rstLine = rstOe_n ? 1'b1 : rstOut;
    assign irqPin = irqCmd;
endmodule
`default_nettype wire

// ===== testbench/pbg_pads_tb_top.sv
// testbench: pad behaviour checks
`timescale 1ns/1ps
`default_nettype none
module pbg_pads_tb_top;
    // ==========
    // signals
    logic clk=0, resetn=0, shutdownReq=0, watchdogExpire=0, serialEnable=0, rxWindow=0;
    logic txWindow=0, selCoreClock=0, coreClock=0, latchStrobe=0, writeStrobeN=1;
    logic readStrobeN=1, fetchStrobeN=1, fetchOrWide=0, port0Drive=0, syncInSelect=0;
    logic serialClk=0, serialData=0, pcmDataOut=0, radio_rx_data=0, frame_sync_io=0;
    logic pcm_bit_clock=0, pcm_tx_strobe=0, pcm_rx_strobe=0, pcm_tx_data_in=0;
    logic strapLow=0, strapHigh=1, triLowIn=0, triHighIn=0, latchPinIn=0;
    logic writePinInN=1, readPinInN=1, ext_irq_a, ext_irq_b, ext_irq_c_or_antenna_switch;
    logic resetPinIn;
    logic [3:0] voiceOut='0;
    logic [1:0] cipherOut='0, coreIrq='0, triLevel;
    logic [8:0] gpoLevel='1, gpoSelect='0;
    logic [2:0] addrDecodeN='1, irqCmd='0, pcmSyncLevel, extIrqFlag;
    logic [15:8] addrHigh='0;
    logic [7:0] port2Latch='0, port0Out='0, port1Latch='1, port1IrqEnable='0;
    logic [7:0] port1PullupOff='0, port1PinIn;
    logic fixed_clock_out, rx_window_strobe, tx_window_strobe, three_level_in_or_gpo_g;
    logic triPinOe_n, decode_sel_a_or_irq_a, decode_sel_b_or_irq_b, latchPinOut;
    logic decode_sel_c_or_core_clock, latchPinOe_n, writePinOutN, readPinOutN;
    logic strobePinOe_n, prog_fetch_strobe, fetchPinOe_n, fetchWeakHigh, sync_serial_dout;
    logic serialClkPin, pcm_rx_data_out, resetPinOut, resetPinOe_n, emulationMode;
    logic testMode, frameSyncPulse, radioRxBit, pcmTxSample;
    logic [5:0] voicePinOut, voicePinOe_n;
    logic [7:0] port0PinOut, port0PinOe_n, port0WeakHigh, port1PinOut, port1PinOe_n;
    logic [7:0] port1WeakHigh, port2PinOut, port2PinOe_n, port1IrqFlag;
    typedef logic [9:0] pbg_row_t;
    pbg_row_t rows [5] = '{10'h2ca, 10'h1a5, 10'h060, 10'h0f0, 10'h3ef};
    int failures = 0;
    int compares = 0;
    int n;
    assign port1PinIn = port1PinOut;
    pbg_pads i_dut (.*);
    pbg_far_side i_far (.irqCmd(irqCmd), .rstOut(resetPinOut), .rstOe_n(resetPinOe_n),
        .irqPin({ext_irq_c_or_antenna_switch, ext_irq_b, ext_irq_a}), .rstLine(resetPinIn));
    initial
    begin
        forever #50 clk = ~clk;
    end
    // ==========
    // helpers
    task chk(input logic [7:0] g, e);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // inputs always move 10 ns after the edge, clear of sampling
    task tick(input int c);
        repeat (c) @(posedge clk);
        #10;
    endtask
    task rst(input logic lo, hi);
        resetn = 0;
        strapLow = lo;
        strapHigh = hi;
        tick(20);
        resetn = 1;
        tick(2);
    endtask
    task results;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========
    // sequence
    initial
    begin
        rst(1'b0, 1'b1);
        chk({testMode, emulationMode, three_level_in_or_gpo_g}, 8'h01);
        chk(triLevel, 8'h01);
        syncInSelect = 1;
        pcmDataOut = 1;
        triLowIn = 1;
        {pcm_tx_data_in, pcm_rx_strobe, pcm_tx_strobe, frame_sync_io, radio_rx_data} = 5'h1f;
        tick(2);
        chk({frameSyncPulse, radioRxBit, pcmSyncLevel, pcmTxSample}, 8'h3d);
        pcm_bit_clock = 1;
        tick(3);
        chk({frameSyncPulse, pcm_rx_data_out, pcmSyncLevel, triLevel}, 8'h3c);
        n = fixed_clock_out;
        tick(pbg_pkg::FIXCLK_HALF);
        chk(8'(fixed_clock_out ^ n[0]), 8'h01);
        for (int i = 0; i < 5; i++)
        begin
            {rxWindow, txWindow, serialEnable, serialData, serialClk, shutdownReq} = rows[i][9:4];
            tick(2);
            chk({rx_window_strobe, tx_window_strobe, sync_serial_dout, serialClkPin},
                {4'h0, rows[i][3:0]});
        end
        for (int k = 0; k < 6; k++)
        begin
            irqCmd = irqCmd ^ (3'h1 << (k % 3));
            n = 0;
            tick(1);
            chk(extIrqFlag, 8'h00);
            repeat (6)
            begin
                tick(1);
                n += (extIrqFlag === (3'h1 << (k % 3)));
            end
            chk(8'(n), 8'h01);
        end
        port1Latch = 8'h00;
        tick(4);
        port1Latch = 8'hff;
        n = 0;
        repeat (6)
        begin
            tick(1);
            n += (port1PinOut === 8'hff && port1PinOe_n === 8'h00);
        end
        chk(8'(n), 8'h02);
        port1IrqEnable = 8'h01;
        port1Latch = 8'hfc;
        n = 0;
        repeat (6)
        begin
            tick(1);
            n += (port1IrqFlag === 8'h01);
        end
        chk(8'(n), 8'h01);
        {fetchOrWide, addrHigh, port2Latch} = 17'h1_a53c;
        tick(1);
        chk(port2PinOut, 8'ha5);
        fetchOrWide = 0;
        tick(1);
        chk(port2PinOut, 8'h3c);
        port0Drive = 1;
        port0Out = 8'h0f;
        gpoLevel = 9'h000;
        gpoSelect = 9'h100;
        addrDecodeN = 3'h5;
        watchdogExpire = 1;
        tick(2);
        chk({three_level_in_or_gpo_g, triPinOe_n, resetPinIn}, 8'h00);
        chk({decode_sel_c_or_core_clock, decode_sel_b_or_irq_b, decode_sel_a_or_irq_a},
            8'h05);
        watchdogExpire = 0;
        shutdownReq = 1;
        tick(2);
        gpoLevel = 9'h1ff;
        voiceOut = 4'hf;
        cipherOut = 2'h3;
        tick(3);
        // frozen levels must survive source changes while shut
        chk({voicePinOut, three_level_in_or_gpo_g, fetchWeakHigh}, 8'h01);
        chk(port0PinOe_n, 8'h0f);
        shutdownReq = 0;
        rst(1'b1, 1'b0);
        coreIrq = 2'h2;
        coreClock = 1;
        watchdogExpire = 1;
        tick(2);
        chk({emulationMode, decode_sel_c_or_core_clock, decode_sel_b_or_irq_b,
            decode_sel_a_or_irq_a}, 8'h0e);
        chk(port0PinOe_n, 8'hff);
        chk({latchPinOe_n, strobePinOe_n, fetchPinOe_n, resetPinIn}, 8'h0f);
        rst(1'b0, 1'b0);
        chk(testMode, 8'h01);
        results();
    end
endmodule
`default_nettype wire
